// File: core/ocfg_bank.sv
// Output configuration register bank behind the three-wire serial port.
`timescale 1ns/1ns
`include "ocfg_defs.svh"

module ocfg_bank
    import ocfg_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_cs_n,
    input  wire logic                  spi_sdio_in,
    output logic                       spi_sdio_out,
    output logic                       spi_sdio_oe,
    output ocfg_clk_out_t  [7:0]       clock_output,
    output ocfg_sref_out_t [7:0]       sysref_output
);

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [2:0]  pins_s;     // Synchronised sclk, cs_n, sdio.
    logic        sclk_s;     // Synchronised serial clock.
    logic        cs_n_s;     // Synchronised chip select, active low.
    logic        sdio_s;     // Synchronised data in.

    ocfg_sync #(.W(3)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({spi_sclk, spi_cs_n, spi_sdio_in}),
        .q   (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign sdio_s = pins_s[0];

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Maps an address to its register kind and output index.
    function automatic ocfg_dec_t decode(input logic [6:0] a);
        ocfg_dec_t d;
        d = '{kind: OCFG_K_NONE, idx: 3'h0};
        case (a)
            `OCFG_CLK_A0_ADDR: d = '{OCFG_K_CLK, 3'h0};
            `OCFG_CLK_A1_ADDR: d = '{OCFG_K_CLK, 3'h1};
            `OCFG_CLK_A2_ADDR: d = '{OCFG_K_CLK, 3'h2};
            `OCFG_CLK_B0_ADDR: d = '{OCFG_K_CLK, 3'h3};
            `OCFG_CLK_B1_ADDR: d = '{OCFG_K_CLK, 3'h4};
            `OCFG_CLK_C0_ADDR: d = '{OCFG_K_CLK, 3'h5};
            `OCFG_CLK_C1_ADDR: d = '{OCFG_K_CLK, 3'h6};
            `OCFG_CLK_D_ADDR:  d = '{OCFG_K_CLK, 3'h7};
            `OCFG_SRC_A0_ADDR: d = '{OCFG_K_SRC, 3'h0};
            `OCFG_SRC_A1_ADDR: d = '{OCFG_K_SRC, 3'h1};
            `OCFG_SRC_A2_ADDR: d = '{OCFG_K_SRC, 3'h2};
            `OCFG_SRC_B0_ADDR: d = '{OCFG_K_SRC, 3'h3};
            `OCFG_SRC_B1_ADDR: d = '{OCFG_K_SRC, 3'h4};
            `OCFG_SRC_C0_ADDR: d = '{OCFG_K_SRC, 3'h5};
            `OCFG_SRC_C1_ADDR: d = '{OCFG_K_SRC, 3'h6};
            `OCFG_SRC_D_ADDR:  d = '{OCFG_K_SRC, 3'h7};
            `OCFG_CFG_A0_ADDR: d = '{OCFG_K_CFG, 3'h0};
            `OCFG_CFG_A1_ADDR: d = '{OCFG_K_CFG, 3'h1};
            `OCFG_CFG_A2_ADDR: d = '{OCFG_K_CFG, 3'h2};
            `OCFG_CFG_B0_ADDR: d = '{OCFG_K_CFG, 3'h3};
            `OCFG_CFG_B1_ADDR: d = '{OCFG_K_CFG, 3'h4};
            `OCFG_CFG_C0_ADDR: d = '{OCFG_K_CFG, 3'h5};
            `OCFG_CFG_C1_ADDR: d = '{OCFG_K_CFG, 3'h6};
            `OCFG_CFG_D_ADDR:  d = '{OCFG_K_CFG, 3'h7};
            `OCFG_CLK_EN_ADDR:  d = '{OCFG_K_CLK_EN, 3'h0};
            `OCFG_SREF_EN_ADDR: d = '{OCFG_K_SREF_EN, 3'h0};
            default: d = '{kind: OCFG_K_NONE, idx: 3'h0};
        endcase
        return d;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    ocfg_state_t s_r;        // Registered state.
    ocfg_state_t s_nxt;      // Next state.
    logic        wr_stb;     // One-cycle write of a whole frame.
    logic [6:0]  wr_addr;    // Address of that write.
    logic [7:0]  wr_data;    // Data of that write.

    // Serial framing, register writes and output decode.
    always_comb begin
        logic        rise;
        logic        fall;
        logic [15:0] sh_new;
        ocfg_dec_t   d;
        logic [7:0]  rv;
        int          sh_i;
        rise   = 1'b0;
        fall   = 1'b0;
        sh_new = '0;
        d      = '{kind: OCFG_K_NONE, idx: 3'h0};
        rv     = 8'h00;
        sh_i   = 0;
        s_nxt   = s_r;
        wr_stb  = 1'b0;
        wr_addr = 7'h00;
        wr_data = 8'h00;
        s_nxt.sclk_d = sclk_s;
        rise = sclk_s & ~s_r.sclk_d;
        fall = ~sclk_s & s_r.sclk_d;
        if (cs_n_s) begin
            // Deselected: frame restarts, data pin released.
            s_nxt.bit_cnt = 5'h00;
            s_nxt.rd_mode = 1'b0;
            s_nxt.sdio_oe = 1'b0;
        end else begin
            if (rise && s_r.bit_cnt < `OCFG_FRAME_BITS) begin
                sh_new = {s_r.sh[14:0], sdio_s};
                s_nxt.sh = sh_new;
                s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
                if (s_r.bit_cnt == `OCFG_HDR_LAST) begin
                    // Header done: latch direction and fetch read data.
                    s_nxt.rd_mode = sh_new[7];
                    d = decode(sh_new[6:0]);
                    case (d.kind)
                        OCFG_K_CLK: begin
                            // Paired partners hold no fields of their own, so they read zero.
                            if (d.idx != 3'h1 && d.idx != 3'h4) begin
                                rv = s_r.clk_reg[d.idx];
                            end
                        end
                        OCFG_K_SRC:     rv = s_r.src_reg[d.idx];
                        OCFG_K_CFG:     rv = s_r.cfg_reg[d.idx];
                        OCFG_K_CLK_EN:  rv = s_r.clk_en;
                        OCFG_K_SREF_EN: rv = s_r.sref_en;
                        default:        rv = 8'h00;
                    endcase
                    s_nxt.rd_sh = rv;
                end
                if (s_r.bit_cnt == `OCFG_DATA_LAST && !s_r.rd_mode) begin
                    wr_stb  = 1'b1;
                    wr_addr = sh_new[14:8];
                    wr_data = sh_new[7:0];
                end
            end
            if (fall) begin
                // Read data leaves MSB first on falling edges.
                if (s_r.rd_mode && s_r.bit_cnt < `OCFG_FRAME_BITS) begin
                    s_nxt.sdio_oe = 1'b1;
                    s_nxt.sdio_o  = s_r.rd_sh[7];
                    s_nxt.rd_sh   = {s_r.rd_sh[6:0], 1'b0};
                end else begin
                    s_nxt.sdio_oe = 1'b0;
                end
            end
        end
        if (wr_stb) begin
            // Only writable bits are stored, so reserved bits read zero.
            d = decode(wr_addr);
            case (d.kind)
                OCFG_K_CLK: begin
                    if (d.idx != 3'h1 && d.idx != 3'h4) begin
                        s_nxt.clk_reg[d.idx] = wr_data & `OCFG_CLK_MASK;
                    end
                end
                OCFG_K_SRC:     s_nxt.src_reg[d.idx] = wr_data & `OCFG_SRC_MASK;
                OCFG_K_CFG:     s_nxt.cfg_reg[d.idx] = wr_data & `OCFG_CFG_MASK;
                OCFG_K_CLK_EN:  s_nxt.clk_en  = wr_data;
                OCFG_K_SREF_EN: s_nxt.sref_en = wr_data;
                default: s_nxt.sh = s_nxt.sh;
            endcase
        end
        // Effective per-output settings; enable bit 7 belongs to output 0.
        for (int i = 0; i < 8; i++) begin
            sh_i = (i == 1) ? 0 : ((i == 4) ? 3 : i);
            s_nxt.clk_o[i] = {s_nxt.clk_en[7-i],
                              s_nxt.clk_reg[sh_i][`OCFG_FMT_BIT],
                              s_nxt.clk_reg[sh_i][`OCFG_AMP_HI:`OCFG_AMP_LO]};
            s_nxt.sref_o[i] = {s_nxt.sref_en[7-i],
                               s_nxt.src_reg[i][`OCFG_SRC_BIT],
                               s_nxt.src_reg[i][`OCFG_DLY_HI:`OCFG_DLY_LO],
                               s_nxt.cfg_reg[i][`OCFG_PD_BIT],
                               s_nxt.cfg_reg[i][`OCFG_BIAS_BIT],
                               s_nxt.cfg_reg[i][`OCFG_FMT_BIT],
                               s_nxt.cfg_reg[i][`OCFG_AMP_HI:`OCFG_AMP_LO]};
        end
    end

    // Registers the state; reset loads the documented defaults.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r         <= '0;
            s_r.sclk_d  <= 1'b1;
            s_r.clk_reg <= {8{`OCFG_CLK_RST}};
            s_r.clk_en  <= `OCFG_CLK_EN_RST;
            s_r.src_reg <= {8{`OCFG_SRC_RST}};
            s_r.cfg_reg <= {8{`OCFG_CFG_RST}};
            s_r.sref_en <= `OCFG_SREF_EN_RST;
            s_r.clk_o   <= {8{4'h9}};
            s_r.sref_o  <= {8{10'h101}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign spi_sdio_out  = s_r.sdio_o;
    assign spi_sdio_oe   = s_r.sdio_oe;
    assign clock_output  = s_r.clk_o;
    assign sysref_output = s_r.sref_o;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    amp_default_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> clock_output[2].amp == 2'h1 && clock_output[7].amp == 2'h1)
        else $error("Clock amplitude default is not 01.");
    amp_shared_a: assert property (@(posedge clk) disable iff (rst)
        clock_output[1].amp == clock_output[0].amp && clock_output[4].amp == clock_output[3].amp)
        else $error("Shared amplitude differs within a pair.");
    fmt_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_stb && wr_addr == `OCFG_CLK_A0_ADDR |=> clock_output[0].fmt == $past(wr_data[4]))
        else $error("Clock format does not follow the written bit.");
    fmt_shared_a: assert property (@(posedge clk) disable iff (rst)
        wr_stb && wr_addr == `OCFG_CLK_B0_ADDR |=> clock_output[4].fmt == $past(wr_data[4]))
        else $error("Shared format did not reach the second output.");
    en_clear_a: assert property (@(posedge clk) disable iff (rst)
        wr_stb && wr_addr == `OCFG_CLK_EN_ADDR && !wr_data[7] |=> !clock_output[0].en)
        else $error("Clock output stays enabled after clear.");
    sref_delay_a: assert property (@(posedge clk) disable iff (rst)
        wr_stb && wr_addr == `OCFG_SRC_D_ADDR |=> sysref_output[7].dly == $past(wr_data[3:1]))
        else $error("Reference delay does not follow the write.");
    sref_en_a: assert property (@(posedge clk) disable iff (rst)
        wr_stb && wr_addr == `OCFG_SREF_EN_ADDR |=> sysref_output[5].en == $past(wr_data[2]))
        else $error("Reference enable bit mapped wrongly.");
    src_default_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> sysref_output[0].src && sysref_output[6].src)
        else $error("Reference source does not default to central.");
    rsvd_ignored_a: assert property (@(posedge clk) disable iff (rst)
        wr_stb && wr_addr == `OCFG_CLK_A1_ADDR |=> $stable(clock_output))
        else $error("Write to a reserved field changed an output.");

endmodule

// File: core/ocfg_defs.svh
// Offsets, field positions, masks and reset values of the output configuration bank.
`ifndef OCFG_DEFS_SVH
`define OCFG_DEFS_SVH

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define OCFG_FRAME_BITS     5'h10
`define OCFG_HDR_LAST       5'h07
`define OCFG_DATA_LAST      5'h0F

// ****************************************************************
// Clock output register offsets, outputs A0 A1 A2 B0 B1 C0 C1 D
// ****************************************************************
`define OCFG_CLK_A0_ADDR    7'h24
`define OCFG_CLK_A1_ADDR    7'h25
`define OCFG_CLK_A2_ADDR    7'h26
`define OCFG_CLK_B0_ADDR    7'h34
`define OCFG_CLK_B1_ADDR    7'h35
`define OCFG_CLK_C0_ADDR    7'h44
`define OCFG_CLK_C1_ADDR    7'h45
`define OCFG_CLK_D_ADDR     7'h54
`define OCFG_CLK_EN_ADDR    7'h74

// ****************************************************************
// System-reference register offsets
// ****************************************************************
`define OCFG_SRC_A0_ADDR    7'h28
`define OCFG_SRC_A1_ADDR    7'h29
`define OCFG_SRC_A2_ADDR    7'h2A
`define OCFG_SRC_B0_ADDR    7'h38
`define OCFG_SRC_B1_ADDR    7'h39
`define OCFG_SRC_C0_ADDR    7'h48
`define OCFG_SRC_C1_ADDR    7'h49
`define OCFG_SRC_D_ADDR     7'h58
`define OCFG_CFG_A0_ADDR    7'h2C
`define OCFG_CFG_A1_ADDR    7'h2D
`define OCFG_CFG_A2_ADDR    7'h2E
`define OCFG_CFG_B0_ADDR    7'h3C
`define OCFG_CFG_B1_ADDR    7'h3D
`define OCFG_CFG_C0_ADDR    7'h4C
`define OCFG_CFG_C1_ADDR    7'h4D
`define OCFG_CFG_D_ADDR     7'h5C
`define OCFG_SREF_EN_ADDR   7'h76

// ****************************************************************
// Field positions
// ****************************************************************
`define OCFG_FMT_BIT        4
`define OCFG_AMP_HI         3
`define OCFG_AMP_LO         2
`define OCFG_SRC_BIT        4
`define OCFG_DLY_HI         3
`define OCFG_DLY_LO         1
`define OCFG_PD_BIT         7
`define OCFG_BIAS_BIT       5

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define OCFG_CLK_MASK       8'h1C
`define OCFG_SRC_MASK       8'h1E
`define OCFG_CFG_MASK       8'hBC
`define OCFG_CLK_RST        8'h04
`define OCFG_SRC_RST        8'h10
`define OCFG_CFG_RST        8'h04
`define OCFG_CLK_EN_RST     8'hFF
`define OCFG_SREF_EN_RST    8'h00

`endif

// File: core/ocfg_pkg.sv
// Types shared by the output configuration bank.
package ocfg_pkg;

    // Kind of register an address selects.
    typedef enum logic [2:0] {
        OCFG_K_NONE,
        OCFG_K_CLK,
        OCFG_K_CLK_EN,
        OCFG_K_SRC,
        OCFG_K_CFG,
        OCFG_K_SREF_EN
    } ocfg_kind_t;

    // Result of an address decode.
    typedef struct packed {
        ocfg_kind_t  kind;  // Register kind.
        logic [2:0]  idx;   // Output index A0..D as 0..7.
    } ocfg_dec_t;

    // Effective settings of one clock output.
    typedef struct packed {
        logic        en;    // Output enabled; low holds the output low.
        logic        fmt;   // 0 low-voltage differential, 1 emitter-coupled.
        logic [1:0]  amp;   // Amplitude code.
    } ocfg_clk_out_t;

    // Effective settings of one system-reference output.
    typedef struct packed {
        logic        en;    // Output enable.
        logic        src;   // 1 central reference, 0 channel clock.
        logic [2:0]  dly;   // Phase delay step.
        logic        pd;    // Power-down.
        logic        bias;  // Output bias mode.
        logic        fmt;   // Output format.
        logic [1:0]  amp;   // Amplitude code.
    } ocfg_sref_out_t;

    // Whole state of the bank.
    typedef struct packed {
        logic                        sclk_d;   // Previous synchronised serial clock.
        logic [4:0]                  bit_cnt;  // Bits taken in this frame.
        logic [15:0]                 sh;       // Incoming shift register.
        logic                        rd_mode;  // Frame is a read.
        logic [7:0]                  rd_sh;    // Outgoing read data.
        logic                        sdio_o;   // Data pin drive value.
        logic                        sdio_oe;  // Data pin drive enable.
        logic [7:0][7:0]             clk_reg;  // Clock output registers.
        logic [7:0]                  clk_en;   // Clock output enables.
        logic [7:0][7:0]             src_reg;  // Reference source and delay registers.
        logic [7:0][7:0]             cfg_reg;  // Reference output registers.
        logic [7:0]                  sref_en;  // Reference output enables.
        logic [7:0][3:0]             clk_o;    // Registered clock output settings.
        logic [7:0][9:0]             sref_o;   // Registered reference output settings.
    } ocfg_state_t;

endpackage

// File: core/ocfg_sync.sv
// Two-stage synchroniser for inputs arriving from outside the clock domain.
`timescale 1ns/1ns

module ocfg_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;  // First stage, read only by the second stage.

    // Both stages load ones so that idle-high lines start idle.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '1;
            q      <= '1;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// File: tb/ocfg_bank_tb_top.sv
// Self-checking testbench for the output configuration register bank.
`timescale 1ns/1ns

module ocfg_bank_tb_top
    import ocfg_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic                  clk;            // System clock, 100 MHz.
    logic                  rst;            // Synchronous reset, active high.
    logic                  spi_sclk;       // Serial clock driven by the bench.
    logic                  spi_cs_n;       // Chip select, active low.
    logic                  spi_sdio_in;    // Serial data into the bank.
    logic                  spi_sdio_out;   // Serial data out of the bank.
    logic                  spi_sdio_oe;    // Bank drives the data pin.
    ocfg_clk_out_t  [7:0]  clock_output;   // Clock output settings.
    ocfg_sref_out_t [7:0]  sysref_output;  // Reference output settings.
    int                    mismatches;     // Count of failed comparisons.
    int                    n_tests;        // Count of comparisons made.
    int                    cyc = 0;        // Cycle counter for the hang guard.
    logic [7:0]            rdat;           // Byte returned by a read frame.
    logic [3:0]            clk_exp [8];    // Expected clock output settings.
    logic [6:0]            src_adr [8];    // Reference source register offsets.
    logic [6:0]            cfg_adr [8];    // Reference output register offsets.

    // ****************************************************************
    // Device under test
    // ****************************************************************
    ocfg_bank u_ocfg_bank (
        .clk           (clk),
        .rst           (rst),
        .spi_sclk      (spi_sclk),
        .spi_cs_n      (spi_cs_n),
        .spi_sdio_in   (spi_sdio_in),
        .spi_sdio_out  (spi_sdio_out),
        .spi_sdio_oe   (spi_sdio_oe),
        .clock_output  (clock_output),
        .sysref_output (sysref_output)
    );

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    // The clock toggles every half period of 5 ns.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A run far longer than the planned frames is cut short as a failure.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end

    // ****************************************************************
    // Helper tasks
    // ****************************************************************
    // Waits n rising edges, then steps just past the edge before driving.
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Compares a value against its expectation and reports a mismatch.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Sends one frame; stop below 16 raises chip select early to abort it.
    // Each serial phase lasts 6 clocks so the two synchroniser flops keep up.
    task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                         input int stop, output logic [7:0] rd_o);
        logic [15:0] f;
        int          i;
        f = {rd, a, wd};
        rd_o = 8'h00;
        spi_cs_n = 1'b0;
        wait_clk(4);
        for (i = 0; i < stop; i++) begin
            spi_sclk = 1'b0;
            spi_sdio_in = f[15-i];
            wait_clk(6);
            // Read data appears after each falling edge of the data phase.
            if (rd && i >= 8) begin
                rd_o = {rd_o[6:0], spi_sdio_out};
                chk(16'(spi_sdio_oe), 16'h0001, "read drive enable");
            end
            spi_sclk = 1'b1;
            wait_clk(6);
        end
        spi_sclk = 1'b0;
        wait_clk(6);
        spi_cs_n = 1'b1;
        spi_sdio_in = ~spi_sdio_in;
        wait_clk(6);
        chk(16'(spi_sdio_oe), 16'h0000, "drive enable after frame");
    endtask

    // Writes one register.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        frame(1'b0, a, d, 16, dummy);
    endtask

    // Reads one register and compares it.
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        frame(1'b1, a, 8'h00, 16, d);
        chk(16'(d), 16'(exp), "register read");
    endtask

    // Compares all clock output settings with the expected table.
    task automatic chk_clk();
        int i;
        for (i = 0; i < 8; i++) begin
            chk(16'(clock_output[i]), 16'(clk_exp[i]), "clock output");
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int         i;
        logic [7:0] en_w;
        rst = 1'b1;
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdio_in = 1'b0;
        mismatches = 0;
        n_tests = 0;
        src_adr = '{7'h28, 7'h29, 7'h2A, 7'h38, 7'h39, 7'h48, 7'h49, 7'h58};
        cfg_adr = '{7'h2C, 7'h2D, 7'h2E, 7'h3C, 7'h3D, 7'h4C, 7'h4D, 7'h5C};
        // Reset is held for five cycles; the outputs already show their defaults.
        clk_exp = '{default: 4'h9};
        wait_clk(5);
        chk_clk();
        rst = 1'b0;
        wait_clk(4);
        // Reset state of every output, the reference and enable registers and clock register A0 after release.
        chk_clk();
        for (i = 0; i < 8; i++) begin
            chk(16'(sysref_output[i]), 16'h0101, "reference output reset");
            rchk(src_adr[i], 8'h10);
            rchk(cfg_adr[i], 8'h04);
        end
        rchk(7'h24, 8'h04);
        rchk(7'h74, 8'hFF);
        rchk(7'h76, 8'h00);
        // Shared pair fields, reserved bits and the ignored partner registers.
        wr(7'h24, 8'hFF);
        wr(7'h25, 8'hFF);
        wr(7'h34, 8'h18);
        wr(7'h44, 8'h14);
        wr(7'h26, 8'h10);
        wr(7'h54, 8'h00);
        clk_exp = '{4'hF, 4'hF, 4'hC, 4'hE, 4'hE, 4'hD, 4'h9, 4'h8};
        chk_clk();
        rchk(7'h24, 8'h1C);
        rchk(7'h44, 8'h14);
        rchk(7'h25, 8'h00);
        // Clock enables: cleared bits hold the output disabled.
        wr(7'h74, 8'h7E);
        clk_exp[0] = 4'h7;
        clk_exp[7] = 4'h0;
        chk_clk();
        rchk(7'h74, 8'h7E);
        // An aborted frame leaves the register untouched.
        frame(1'b0, 7'h24, 8'h00, 12, rdat);
        rchk(7'h24, 8'h1C);
        chk_clk();
        // Unmapped addresses read zero and ignore writes.
        wr(7'h7F, 8'hFF);
        rchk(7'h7F, 8'h00);
        rchk(7'h23, 8'h00);
        // Every reference output gets its own distinct settings.
        for (i = 0; i < 8; i++) begin
            wr(src_adr[i], 8'hE1 | 8'(i << 1));
            wr(cfg_adr[i], {i[0], 1'b1, i[1], i[2], 4'hB});
        end
        wr(7'h76, 8'hA5);
        en_w = 8'hA5;
        for (i = 0; i < 8; i++) begin
            rchk(src_adr[i], {4'h0, i[2:0], 1'b0});
            rchk(cfg_adr[i], {i[0], 1'b0, i[1], i[2], 4'h8});
            chk(16'(sysref_output[i]),
                16'({en_w[7-i], 1'b0, i[2:0], i[0], i[1], i[2], 2'b10}),
                "reference output");
        end
        rchk(7'h76, 8'hA5);
        chk_clk();
        finish_test();
    end

endmodule
